/* File: inc/tmr_map.vh */
`ifndef TMR_MAP_VH
`define TMR_MAP_VH
// register indices; each register is one word at four times its index
`define TMR_CMPA_IDX 12'h010
`define TMR_CMPB_IDX 12'h012
`define TMR_CTRL_IDX 12'h014
`define TMR_CMPA 12'h040
`define TMR_CMPB 12'h048
`define TMR_CTRL 12'h050
`define TMR_IRQ_STAT 12'h020
`define TMR_IRQ_MASK 12'h024
`define TMR_COUNT 12'h028
// reset values
`define TMR_CMP_RST 16'hFFFF
`define TMR_CTRL_RST 8'h00
// control field positions
`define TMR_F_MODE_LO 0
`define TMR_F_CK_LO 2
`define TMR_F_START_LO 4
`define TMR_F_ONESHOT 6
`define TMR_F_TRIGSTOP 6
`define TMR_F_EDGE 6
`define TMR_F_ACAP 6
`define TMR_F_TFF 7
// modes
`define TMR_MODE_TIMER 2'h0
`define TMR_MODE_WINDOW 2'h1
`define TMR_MODE_PWM 2'h2
`define TMR_MODE_PPG 2'h3
// source clock select
`define TMR_CK_EXT 2'h3
// prescaler tap exponents (divide by 2^n)
`define TMR_TAP0 11
`define TMR_TAP0_ALT 3
`define TMR_TAP1 7
`define TMR_TAP2 3
// noise filter: 4/fc rejected, 12/fc detected; fc = clk here
`define TMR_FILT_REJECT 4
`define TMR_FILT_DETECT 12
`define TMR_FILT_CYC 8
// interrupt status bits
`define TMR_IRQ_MATCH 0
`define TMR_IRQ_CAPT 1
`endif

/* File: rtl/tmr_pin_filter.v */
`timescale 1ns/1ps
`default_nettype none
`include "tmr_map.vh"
module tmr_pin_filter (
	// clock and reset
	input wire clk,
	input wire rst,
	// raw pin and filtered level
	input wire pinIn,
	output wire pinOut
);
	reg [3:0] cnt_ff;
	reg lvl_ff;
	reg [3:0] nxt_cnt;
	reg nxt_lvl;
	always @* begin
		nxt_cnt = 4'h0;
		nxt_lvl = lvl_ff;
		if (pinIn != lvl_ff) begin
			// a level must persist for 8 clocks (TMR_FILT_CYC), past the reject width
			if (cnt_ff == (`TMR_FILT_CYC - 1))
				nxt_lvl = pinIn;
			else
				nxt_cnt = cnt_ff + 4'h1;
		end
	end
	always @(posedge clk) begin
		if (rst) begin
			cnt_ff <= 4'h0;
			lvl_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			lvl_ff <= nxt_lvl;
		end
	end
	assign pinOut = lvl_ff;
endmodule // tmr_pin_filter
`default_nettype wire

/* File: rtl/tmr_timer16.v */
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "tmr_map.vh"
// Overview of operation
// - one 8-bit control and two 16-bit compare registers, each written whole in one access
// - compare values are buffered and load on first source tick after a write
// - auto-capture acts only in timer and window modes
// - stop mode entry clears start field and halts the counter
// - captured value is valid only while capture runs
// - auto-capture copies the counter into B every source tick; PWM capture copies it on the opposite pin edge
// - timer mode match raises interrupt and restarts counter at zero
// - pin filter rejects 4/fc pulses and detects 12/fc pulses
module tmr_timer16 (
	// clock and reset
	input wire clk,
	input wire rst,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// system
	input wire stopEnter,
	input wire prescalerTapSelect,
	input wire externalTimerPin,
	// outputs
	output reg programmablePulseOutput,
	output reg timerInterrupt
);

	// control and compare state
	reg [7:0] ctrl_ff;
	reg [15:0] cmpA_ff;
	reg [15:0] cmpB_ff;
	reg [15:0] bufA_ff;
	reg [15:0] bufB_ff;
	reg pendA_ff;
	reg pendB_ff;

	// counting state
	reg [15:0] cnt_ff;
	reg [10:0] pre_ff;
	reg run_ff;
	reg ppg_ff;
	reg pinDly_ff;

	// interrupt state
	reg [1:0] stat_ff;
	reg [1:0] mask_ff;

	// next values
	reg [7:0] nxt_ctrl;
	reg [15:0] nxt_cmpA;
	reg [15:0] nxt_cmpB;
	reg [15:0] nxt_bufA;
	reg [15:0] nxt_bufB;
	reg nxt_pendA;
	reg nxt_pendB;
	reg [15:0] nxt_cnt;
	reg nxt_run;
	reg nxt_ppg;
	wire [1:0] nxt_stat;
	reg [1:0] nxt_mask;
	reg [31:0] nxt_prdata;
	reg srcTick;
	reg cntEn;

	wire pinLvl;

	// control fields
	wire [1:0] mode = ctrl_ff[`TMR_F_MODE_LO+1:`TMR_F_MODE_LO];
	wire [1:0] ckSel = ctrl_ff[`TMR_F_CK_LO+1:`TMR_F_CK_LO];
	wire [1:0] start = ctrl_ff[`TMR_F_START_LO+1:`TMR_F_START_LO];
	wire acap = ctrl_ff[`TMR_F_ACAP];
	wire oneShot = ctrl_ff[`TMR_F_ONESHOT];
	wire flipInit = ctrl_ff[`TMR_F_TFF];
	wire active = (start != 2'h0);

	// apb decode
	wire apbSetup = psel && !penable;
	wire apbWr = psel && penable && pready && pwrite;
	wire selCmpA = (paddr == `TMR_CMPA);
	wire selCmpB = (paddr == `TMR_CMPB);
	wire selCtrl = (paddr == `TMR_CTRL);
	wire selStat = (paddr == `TMR_IRQ_STAT);
	wire selMask = (paddr == `TMR_IRQ_MASK);
	wire selCount = (paddr == `TMR_COUNT);
	wire mapped = selCmpA || selCmpB || selCtrl || selStat || selMask || selCount;

	// write strobes at the completing edge
	wire wrCmpA = apbWr && selCmpA;
	wire wrCmpB = apbWr && selCmpB;
	wire wrCtrl = apbWr && selCtrl;
	wire wrStat = apbWr && selStat;
	wire wrMask = apbWr && selMask;

	// signal filter for the external pin
	tmr_pin_filter uFilt (
		.clk(clk),
		.rst(rst),
		.pinIn(externalTimerPin),
		.pinOut(pinLvl)
	);

	// edge detection on filtered pin
	wire pinRise = pinLvl && !pinDly_ff;
	wire pinFall = !pinLvl && pinDly_ff;

	// start field bit0 picks falling edge in edge modes
	wire edgeSel = start[0] ? pinFall : pinRise;
	wire edgeOpp = start[0] ? pinRise : pinFall;

	// prescaler taps
	wire [10:0] preNxt = pre_ff + 11'h001;
	wire tap0 = prescalerTapSelect ? (pre_ff[`TMR_TAP0_ALT-1:0] == 3'h7)
		: (pre_ff == 11'h7FF);
	wire tap1 = (pre_ff[`TMR_TAP1-1:0] == 7'h7F);
	wire tap2 = (pre_ff[`TMR_TAP2-1:0] == 3'h7);

	// source clock select
	always @* begin
		case (ckSel)
		2'h0: srcTick = tap0;
		2'h1: srcTick = tap1;
		2'h2: srcTick = tap2;
		default: srcTick = edgeSel;
		endcase
	end

	// count enable per mode
	always @* begin
		case (mode)
		`TMR_MODE_WINDOW: cntEn = active && srcTick && (pinLvl ^ start[0]);
		`TMR_MODE_PWM: cntEn = active && run_ff && srcTick;
		default: cntEn = active && run_ff && srcTick;
		endcase
	end

	// events
	wire matchA = cntEn && (cnt_ff == cmpA_ff);
	wire capOk = acap && (mode != `TMR_MODE_PWM) && (mode != `TMR_MODE_PPG);
	wire pwmCap = active && (mode == `TMR_MODE_PWM) && run_ff && edgeOpp;
	wire evMatch = matchA && (mode != `TMR_MODE_PWM);
	wire autoCap = active && capOk && srcTick;
	wire [1:0] evSet = {pwmCap, evMatch};

	// control register
	always @* begin
		nxt_ctrl = ctrl_ff;
		if (wrCtrl)
			nxt_ctrl = pwdata[7:0];
		if (stopEnter)
			nxt_ctrl[`TMR_F_START_LO+1:`TMR_F_START_LO] = 2'h0;
	end

	// compare A: buffered, loads on next source tick
	always @* begin
		nxt_bufA = bufA_ff;
		nxt_pendA = pendA_ff;
		nxt_cmpA = cmpA_ff;
		if (pendA_ff && srcTick) begin
			nxt_cmpA = bufA_ff;
			nxt_pendA = 1'b0;
		end
		if (wrCmpA) begin
			nxt_bufA = pwdata[15:0];
			nxt_pendA = 1'b1;
		end
	end

	// compare/capture B: writes taken in pulse output mode only
	always @* begin
		nxt_bufB = bufB_ff;
		nxt_pendB = pendB_ff;
		nxt_cmpB = cmpB_ff;
		if (pendB_ff && srcTick) begin
			nxt_cmpB = bufB_ff;
			nxt_pendB = 1'b0;
		end
		if (wrCmpB && mode == `TMR_MODE_PPG) begin
			nxt_bufB = pwdata[15:0];
			nxt_pendB = 1'b1;
		end
		if (autoCap)
			nxt_cmpB = cnt_ff;
		else if (pwmCap)
			nxt_cmpB = cnt_ff;
	end

	// interrupt mask
	always @* begin
		nxt_mask = mask_ff;
		if (wrMask)
			nxt_mask = pwdata[1:0];
	end

	// status flags: write one to clear, set wins
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : gStat
			assign nxt_stat[g] = evSet[g] || (stat_ff[g] && !(wrStat && pwdata[g]));
		end
	endgenerate

	// counter and run state
	always @* begin
		nxt_cnt = cnt_ff;
		nxt_run = run_ff;
		nxt_ppg = ppg_ff;
		if (!active || stopEnter) begin
			nxt_cnt = 16'h0000;
			nxt_run = 1'b0;
			nxt_ppg = flipInit;
		end else begin
			if (mode == `TMR_MODE_TIMER && start == 2'h1)
				nxt_run = 1'b1;
			else if (!run_ff && edgeSel)
				nxt_run = 1'b1;
			if (pwmCap) begin
				nxt_cnt = 16'h0000;
				nxt_run = 1'b0;
			end else if (matchA) begin
				nxt_cnt = 16'h0000;
				if (mode == `TMR_MODE_PPG && oneShot)
					nxt_run = 1'b0;
			end else if (cntEn) begin
				nxt_cnt = cnt_ff + 16'h0001;
			end
			if (mode == `TMR_MODE_PPG && cntEn && (cnt_ff == cmpB_ff || cnt_ff == cmpA_ff))
				nxt_ppg = ~ppg_ff;
		end
	end

	// apb read mux
	always @* begin
		nxt_prdata = 32'h00000000;
		case (paddr)
		`TMR_CMPA: nxt_prdata = {16'h0000, cmpA_ff};
		`TMR_CMPB: nxt_prdata = {16'h0000, cmpB_ff};
		`TMR_CTRL: nxt_prdata = {24'h000000, ctrl_ff};
		`TMR_IRQ_STAT: nxt_prdata = {30'h00000000, stat_ff};
		`TMR_IRQ_MASK: nxt_prdata = {30'h00000000, mask_ff};
		`TMR_COUNT: nxt_prdata = {16'h0000, cnt_ff};
		default: nxt_prdata = 32'h00000000;
		endcase
	end

	// control and compare registers
	always @(posedge clk) begin
		if (rst) begin
			ctrl_ff <= `TMR_CTRL_RST;
			cmpA_ff <= `TMR_CMP_RST;
			cmpB_ff <= `TMR_CMP_RST;
			bufA_ff <= `TMR_CMP_RST;
			bufB_ff <= `TMR_CMP_RST;
			pendA_ff <= 1'b0;
			pendB_ff <= 1'b0;
		end else begin
			ctrl_ff <= nxt_ctrl;
			cmpA_ff <= nxt_cmpA;
			cmpB_ff <= nxt_cmpB;
			bufA_ff <= nxt_bufA;
			bufB_ff <= nxt_bufB;
			pendA_ff <= nxt_pendA;
			pendB_ff <= nxt_pendB;
		end
	end

	// counting registers
	always @(posedge clk) begin
		if (rst) begin
			cnt_ff <= 16'h0000;
			pre_ff <= 11'h000;
			run_ff <= 1'b0;
			ppg_ff <= 1'b0;
			pinDly_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			pre_ff <= preNxt;
			run_ff <= nxt_run;
			ppg_ff <= nxt_ppg;
			pinDly_ff <= pinLvl;
		end
	end

	// interrupt registers
	always @(posedge clk) begin
		if (rst) begin
			stat_ff <= 2'h0;
			mask_ff <= 2'h0;
		end else begin
			stat_ff <= nxt_stat;
			mask_ff <= nxt_mask;
		end
	end

	// ready pulse in the access cycle
	always @(posedge clk) begin
		if (rst)
			pready <= 1'b0;
		else
			pready <= apbSetup;
	end

	// error with ready for unmapped addresses
	always @(posedge clk) begin
		if (rst)
			pslverr <= 1'b0;
		else
			pslverr <= apbSetup && !mapped;
	end

	// read data with ready
	always @(posedge clk) begin
		if (rst)
			prdata <= 32'h00000000;
		else
			prdata <= apbSetup ? nxt_prdata : 32'h00000000;
	end

	// level interrupt output
	always @(posedge clk) begin
		if (rst)
			timerInterrupt <= 1'b0;
		else
			timerInterrupt <= |(stat_ff & mask_ff);
	end

	// pulse output
	always @(posedge clk) begin
		if (rst)
			programmablePulseOutput <= 1'b0;
		else
			programmablePulseOutput <= ppg_ff;
	end

endmodule // tmr_timer16
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tmr_map.vh"
module tb;
	logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd, b;
	logic stopEnter = 0, prescalerTapSelect = 0, externalTimerPin = 0, programmablePulseOutput, timerInterrupt;
	int bad_count = 0, checks = 0, i;
	tmr_timer16 dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.stopEnter, .prescalerTapSelect, .externalTimerPin, .programmablePulseOutput, .timerInterrupt);
	initial forever #50 clk = ~clk;
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		do @(posedge clk); while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic pins(input int hi);
		repeat (6) begin
			@(posedge clk) externalTimerPin <= 1'h1;
			repeat (hi) @(posedge clk);
			externalTimerPin <= 1'h0;
			repeat (20) @(posedge clk);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d errors %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		complete_run;
	end
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		acc(1'h0, `TMR_CMPA, 32'h0);
		chk("cmpA reset", rd, 32'h0000FFFF);
		acc(1'h0, `TMR_CMPB, 32'h0);
		chk("cmpB reset", rd, 32'h0000FFFF);
		acc(1'h0, `TMR_CTRL, 32'h0);
		chk("ctrl reset", rd, 32'h0);
		acc(1'h0, 12'h030, 32'h0);
		chk("unmapped", {rd[30:0], err}, 32'h1);
		// timer match with interrupt masked and unmasked
		acc(1'h1, `TMR_CMPA, 32'h4);
		acc(1'h1, `TMR_IRQ_MASK, 32'h1);
		acc(1'h1, `TMR_CTRL, 32'h08);
		acc(1'h1, `TMR_CTRL, 32'h18);
		for (i = 0; i < 400 && timerInterrupt !== 1'h1; i++) @(posedge clk);
		chk("match irq", timerInterrupt, 1'h1);
		acc(1'h1, `TMR_CTRL, 32'h08);
		acc(1'h1, `TMR_IRQ_MASK, 32'h0);
		acc(1'h0, `TMR_IRQ_STAT, 32'h0);
		chk("masked irq", {rd[0], timerInterrupt}, 32'h2);
		acc(1'h1, `TMR_IRQ_STAT, 32'h1);
		acc(1'h1, `TMR_IRQ_MASK, 32'h1);
		acc(1'h0, `TMR_IRQ_STAT, 32'h0);
		chk("cleared", {rd[0], timerInterrupt}, 32'h0);
		// stop mode entry while running
		acc(1'h1, `TMR_CTRL, 32'h18);
		@(posedge clk) stopEnter <= 1'h1;
		@(posedge clk) stopEnter <= 1'h0;
		acc(1'h0, `TMR_CTRL, 32'h0);
		chk("stop ctrl", rd[7:0], 32'h08);
		acc(1'h0, `TMR_COUNT, 32'h0);
		b = rd;
		repeat (40) @(posedge clk);
		acc(1'h0, `TMR_COUNT, 32'h0);
		chk("halted", rd, b);
		// auto capture on fast tap
		prescalerTapSelect <= 1'h1;
		acc(1'h1, `TMR_CMPA, 32'h0100);
		acc(1'h1, `TMR_CTRL, 32'h48);
		acc(1'h1, `TMR_CTRL, 32'h58);
		repeat (40) @(posedge clk);
		acc(1'h0, `TMR_CMPB, 32'h0);
		b = rd;
		acc(1'h0, `TMR_COUNT, 32'h0);
		chk("capture", {b[15:8], 1'h0, rd >= b}, 32'h1);
		// filtered pin as source clock
		acc(1'h1, `TMR_CTRL, 32'h48);
		acc(1'h1, `TMR_CTRL, 32'h0C);
		acc(1'h1, `TMR_CMPA, 32'h2);
		acc(1'h1, `TMR_IRQ_STAT, 32'h3);
		acc(1'h1, `TMR_CTRL, 32'h1C);
		pins(4);
		acc(1'h0, `TMR_IRQ_STAT, 32'h0);
		chk("glitch", rd[0], 1'h0);
		pins(12);
		acc(1'h0, `TMR_IRQ_STAT, 32'h0);
		chk("pin pulses", rd[0], 1'h1);
		// B written only in pulse mode; output shows flip-flop level
		acc(1'h1, `TMR_CTRL, 32'h0C);
		acc(1'h1, `TMR_CTRL, 32'h08);
		acc(1'h0, `TMR_CMPB, 32'h0);
		b = rd;
		acc(1'h1, `TMR_CMPB, 32'h4);
		repeat (20) @(posedge clk);
		acc(1'h0, `TMR_CMPB, 32'h0);
		chk("B refused", rd, b);
		acc(1'h1, `TMR_CTRL, 32'h8B);
		acc(1'h1, `TMR_CMPA, 32'h10);
		acc(1'h1, `TMR_CMPB, 32'h4);
		repeat (20) @(posedge clk);
		acc(1'h0, `TMR_CMPB, 32'h0);
		chk("B loaded", rd, 32'h4);
		chk("pulse level", programmablePulseOutput, 1'h1);
		complete_run;
	end
endmodule // tb
`default_nettype wire

/* File: tb/tmr_timer16_checker.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tmr_map.vh"
module tmr_timer16_checker (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// outputs
	input wire logic programmablePulseOutput,
	input wire logic timerInterrupt
);
	wire logic mapped = paddr inside {`TMR_CMPA, `TMR_CMPB, `TMR_CTRL, `TMR_IRQ_STAT, `TMR_IRQ_MASK, `TMR_COUNT};
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	chk_ready_setup: assert property (psel && !penable |=> pready) else $error("no ready after setup");
	chk_ready_access: assert property (pready |-> psel && penable) else $error("ready outside access");
	chk_ready_pulse: assert property (pready |=> !pready) else $error("ready held too long");
	chk_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
	chk_unmapped_err: assert property (pready && !mapped |-> pslverr) else $error("unmapped not refused");
	chk_mapped_ok: assert property (pready && mapped |-> !pslverr) else $error("mapped refused");
	chk_unmapped_zero: assert property (pready && !mapped && !pwrite |-> prdata == 32'h0)
		else $error("unmapped read not zero");
	chk_reset_quiet: assert property (disable iff (1'h0) rst |=> !pready && !timerInterrupt
		&& !programmablePulseOutput) else $error("outputs active after reset");
endmodule // tmr_timer16_checker
bind tmr_timer16 tmr_timer16_checker chk (.clk, .rst, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
	.pslverr, .programmablePulseOutput, .timerInterrupt);
`default_nettype wire
